// ==== rtl/pgs_supervisor.sv ====
// global supervisor: supply monitors, on-key debounce, wake-up, interrupts, chip id
// Overview of operation
// - all logic held in reset while supply is below the power-on threshold
// - undervoltage comparator ignored while in standby
// - leaving standby checks undervoltage; go resource-on if fine, else standby
// - overvoltage comparator disabled while in standby
// - operation inhibited while system supply is over the lockout threshold
// - shut down when junction temperature exceeds the shutdown limit
// - on-key debounced with time selectable between 500us and 30ms
// - on-key mode bit: 0 push-button, 1 slide-switch
// - debounced falling on-key edge starts power-up in both modes
// - separate rising and falling on-key interrupt flags, each with mask
// - charger insertion wakes only after 120ms of stable presence
// - every interrupt source has its own mask bit
// - read-only chip option id field in bits 4:0
// - in resource-on, on-key held pressed (push-button) or released (slide-switch) for manual-reset time powers down
// - interrupt output low while any unmasked flag set; masks reset masked
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pgs_map.svh"
module pgs_supervisor
  import pgs_pkg::*;
#(
  parameter logic [4:0] CHIP_OPTION_ID = 5'h0A, // arbitrary value
  parameter int DBNC_SHORT_CYC = `PGS_DBNC_SHORT_CYC,
  parameter int DBNC_LONG_CYC = `PGS_DBNC_LONG_CYC,
  parameter int CHG_DBNC_CYC = `PGS_CHG_DBNC_CYC,
  parameter int MRST_SHORT_CYC = `PGS_MRST_SHORT_CYC,
  parameter int MRST_LONG_CYC = `PGS_MRST_LONG_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic supply_por_reset_flag_i,
  input wire logic supply_undervoltage_flag_i,
  input wire logic sys_overvoltage_flag_i,
  input wire logic thermal_shutdown_flag_i,
  input wire logic on_key_input_n_i,
  input wire logic charger_input_supply_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic wb_sel_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  output logic uvlo_enable_o,
  output logic ovlo_enable_o,
  output logic resource_on_o,
  output logic power_up_start_o,
  output logic power_down_start_o,
  output logic interrupt_out_n_o,
  output logic interrupt_out_n_oe_o
);
  localparam int CW = 30;

  // the supply power-on reset joins the system reset so nothing runs below threshold
  logic por_meta_reg;
  logic por_sync_reg;
  logic rst_all;
  always_ff @(posedge clk_i) begin
    por_meta_reg <= supply_por_reset_flag_i;
    por_sync_reg <= por_meta_reg;
  end
  assign rst_all = rst_i | por_sync_reg;

  // two-flop synchronisers for all asynchronous monitor and pin inputs
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  always_ff @(posedge clk_i) begin
    sync1_reg <= {charger_input_supply_i, on_key_input_n_i, thermal_shutdown_flag_i,
                  sys_overvoltage_flag_i, supply_undervoltage_flag_i};
    sync2_reg <= sync1_reg;
  end
  wire uv_s = sync2_reg[0];
  wire ov_s = sync2_reg[1];
  wire th_s = sync2_reg[2];
  wire key_s = sync2_reg[3];
  wire chg_s = sync2_reg[4];

  logic [7:0] cfg_reg;
  logic [7:0] mask_reg;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  pgs_state_t state_reg;
  pgs_state_t state_next;

  wire dbnc_long = cfg_reg[`PGS_CFG_DBNC_BIT];
  wire slide_mode = cfg_reg[`PGS_CFG_MODE_BIT];
  wire mrst_long = cfg_reg[`PGS_CFG_MRST_BIT];

  // on-key debouncer
  logic key_db_reg;
  logic [CW-1:0] key_cnt_reg;
  wire [CW-1:0] key_limit = dbnc_long ? CW'(DBNC_LONG_CYC) : CW'(DBNC_SHORT_CYC);
  wire key_differs = key_s != key_db_reg;
  wire key_accept = key_differs && (key_cnt_reg >= key_limit - CW'(1));
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      key_db_reg <= 1'b1;
      key_cnt_reg <= '0;
    end else if (!key_differs) begin
      key_cnt_reg <= '0;
    end else if (key_accept) begin
      key_db_reg <= key_s;
      key_cnt_reg <= '0;
    end else begin
      key_cnt_reg <= key_cnt_reg + CW'(1);
    end
  end
  wire key_fall = key_accept && !key_s;
  wire key_rise = key_accept && key_s;

  // charger presence debouncer; wake only on stable insertion
  logic chg_db_reg;
  logic [CW-1:0] chg_cnt_reg;
  wire chg_differs = chg_s != chg_db_reg;
  wire chg_accept = chg_differs && (chg_cnt_reg >= CW'(CHG_DBNC_CYC) - CW'(1));
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      chg_db_reg <= 1'b0;
      chg_cnt_reg <= '0;
    end else if (!chg_differs) begin
      chg_cnt_reg <= '0;
    end else if (chg_accept) begin
      chg_db_reg <= chg_s;
      chg_cnt_reg <= '0;
    end else begin
      chg_cnt_reg <= chg_cnt_reg + CW'(1);
    end
  end
  wire chg_insert = chg_accept && chg_s;

  // manual reset timer: key held at its "off" level in resource-on
  logic [CW-1:0] mrst_cnt_reg;
  wire key_off_level = slide_mode ? key_db_reg : !key_db_reg;
  wire [CW-1:0] mrst_limit = mrst_long ? CW'(MRST_LONG_CYC) : CW'(MRST_SHORT_CYC);
  wire mrst_hold = (state_reg == PGS_RESOURCE_ON) && key_off_level;
  wire mrst_fire = mrst_hold && (mrst_cnt_reg >= mrst_limit - CW'(1));
  always_ff @(posedge clk_i) begin
    if (rst_all || !mrst_hold || mrst_fire) begin
      mrst_cnt_reg <= '0;
    end else begin
      mrst_cnt_reg <= mrst_cnt_reg + CW'(1);
    end
  end

  // on/off controller
  wire in_standby = state_reg == PGS_STANDBY;
  wire uv_eff = uv_s && !in_standby;
  wire ov_eff = ov_s && !in_standby;
  wire wake = key_fall || chg_insert;
  wire fault_off = ov_eff || th_s;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PGS_STANDBY: begin
        if (wake && !th_s && !ov_s) begin
          state_next = PGS_UV_CHECK;
        end
      end
      PGS_UV_CHECK: begin
        if (uv_eff || fault_off) begin
          state_next = PGS_STANDBY;
        end else begin
          state_next = PGS_RESOURCE_ON;
        end
      end
      PGS_RESOURCE_ON: begin
        if (uv_eff || fault_off || mrst_fire) begin
          state_next = PGS_STANDBY;
        end
      end
      default: state_next = PGS_STANDBY;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      state_reg <= PGS_STANDBY;
    end else begin
      state_reg <= state_next;
    end
  end
  wire pu_start = (state_reg == PGS_UV_CHECK) && (state_next == PGS_RESOURCE_ON);
  wire pd_start = (state_reg == PGS_RESOURCE_ON) && (state_next == PGS_STANDBY);
  logic pu_reg;
  logic pd_reg;
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      pu_reg <= 1'b0;
      pd_reg <= 1'b0;
    end else begin
      pu_reg <= pu_start;
      pd_reg <= pd_start;
    end
  end
  assign power_up_start_o = pu_reg;
  assign power_down_start_o = pd_reg;
  assign uvlo_enable_o = !in_standby;
  assign ovlo_enable_o = !in_standby;
  assign resource_on_o = state_reg == PGS_RESOURCE_ON;

  // wishbone slave, one registered ack per request, a cycle after the strobe
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_en = bus_req && wb_we_i && wb_sel_i;
  wire rd_flags = bus_req && !wb_we_i && (wb_adr_i == `PGS_ADDR_IRQ_FLAGS);
  wire hit_cfg = wb_adr_i == `PGS_ADDR_CONFIG;
  wire hit_mask = wb_adr_i == `PGS_ADDR_IRQ_MASK;
  wire [7:0] status_val = {3'b000, chg_db_reg, key_db_reg, th_s, state_reg};
  wire [7:0] rd_val =
    (wb_adr_i == `PGS_ADDR_CONFIG) ? cfg_reg :
    (wb_adr_i == `PGS_ADDR_IRQ_FLAGS) ? flags_reg :
    (wb_adr_i == `PGS_ADDR_IRQ_MASK) ? mask_reg :
    (wb_adr_i == `PGS_ADDR_STATUS) ? status_val :
    (wb_adr_i == `PGS_ADDR_CHIP_ID) ? {3'b000, CHIP_OPTION_ID} : 8'h00;

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 8'h00;
      cfg_reg <= `PGS_CFG_RESET;
      mask_reg <= `PGS_MASK_RESET;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= rd_val;
      end
      if (wr_en && hit_cfg) begin
        cfg_reg <= {5'b00000, wb_dat_i[2:0]};
      end
      if (wr_en && hit_mask) begin
        mask_reg <= {4'h0, wb_dat_i[3:0]};
      end
    end
  end

  // sticky flags: read clears, but a new event in the same cycle wins
  wire [7:0] events = {4'h0, th_s, chg_insert, key_rise, key_fall};
  always_comb begin
    flags_next = rd_flags ? 8'h00 : flags_reg;
    flags_next = flags_next | events;
  end
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      flags_reg <= 8'h00;
    end else begin
      flags_reg <= flags_next;
    end
  end
  // open-drain: pull low when any unmasked flag is set
  wire irq_any = |(flags_reg & ~mask_reg);
  assign interrupt_out_n_o = 1'b0;
  assign interrupt_out_n_oe_o = irq_any;

  a_uv_standby_off: assert property (@(posedge clk_i) disable iff (rst_all)
    (state_reg == PGS_STANDBY) |-> !uvlo_enable_o && !ovlo_enable_o)
    else $error("monitors enabled in standby");
  a_uv_check_back: assert property (@(posedge clk_i) disable iff (rst_all)
    (state_reg == PGS_UV_CHECK && uv_s) |=> state_reg == PGS_STANDBY)
    else $error("undervoltage did not return to standby");
  a_uv_check_on: assert property (@(posedge clk_i) disable iff (rst_all)
    (state_reg == PGS_UV_CHECK && !uv_s && !ov_s && !th_s) |=> state_reg == PGS_RESOURCE_ON && power_up_start_o)
    else $error("good supply did not reach resource-on");
  a_ov_inhibit: assert property (@(posedge clk_i) disable iff (rst_all)
    (state_reg == PGS_RESOURCE_ON && ov_s) |=> state_reg == PGS_STANDBY)
    else $error("overvoltage did not inhibit");
  a_thermal_off: assert property (@(posedge clk_i) disable iff (rst_all)
    th_s |=> state_reg != PGS_RESOURCE_ON)
    else $error("thermal shutdown ignored");
  sequence s_key_fall;
    key_fall && state_reg == PGS_STANDBY && !th_s && !ov_s;
  endsequence
  a_fall_wakes: assert property (@(posedge clk_i) disable iff (rst_all)
    s_key_fall |=> state_reg == PGS_UV_CHECK)
    else $error("falling on-key did not wake");
  a_debounce_stable: assert property (@(posedge clk_i) disable iff (rst_all)
    $changed(key_db_reg) |-> $past(key_s) == key_db_reg && $past(key_s, 2) == key_db_reg)
    else $error("debounced level taken without stable input");
  a_rise_flag: assert property (@(posedge clk_i) disable iff (rst_all)
    key_rise |=> flags_reg[`PGS_IRQ_RISE_BIT])
    else $error("rising flag not set");
  a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_all)
    (flags_reg[`PGS_IRQ_FALL_BIT] && !rd_flags) |=> flags_reg[`PGS_IRQ_FALL_BIT])
    else $error("falling flag cleared without read");
  // an unmasked event must reach the pin one cycle later; a mask write in that cycle is left out
  a_irq_level: assert property (@(posedge clk_i) disable iff (rst_all)
    (((events & ~mask_reg) != 8'h00) && !(wr_en && hit_mask)) |=> interrupt_out_n_oe_o && !interrupt_out_n_o)
    else $error("unmasked event did not pull the interrupt low");
endmodule
`default_nettype wire

// ==== shared/pgs_map.svh ====
// register offsets, field positions, reset values and timing counts of the global supervisor
`ifndef PGS_MAP_SVH
`define PGS_MAP_SVH
`define PGS_CLK_HZ 100000000
`define PGS_ADDR_CONFIG 4'h0
`define PGS_ADDR_IRQ_FLAGS 4'h1
`define PGS_ADDR_IRQ_MASK 4'h2
`define PGS_ADDR_STATUS 4'h3
`define PGS_ADDR_CHIP_ID 4'h4
`define PGS_CFG_DBNC_BIT 0
`define PGS_CFG_MODE_BIT 1
`define PGS_CFG_MRST_BIT 2
`define PGS_CFG_RESET 8'h00
`define PGS_MASK_RESET 8'h0F
`define PGS_IRQ_FALL_BIT 0
`define PGS_IRQ_RISE_BIT 1
`define PGS_IRQ_CHG_BIT 2
`define PGS_IRQ_THERM_BIT 3
`define PGS_DBNC_SHORT_US 500
`define PGS_DBNC_LONG_MS 30
`define PGS_CHG_DBNC_MS 120
`define PGS_MRST_SHORT_MS 3300
`define PGS_MRST_LONG_MS 8000
`define PGS_DBNC_SHORT_CYC (`PGS_DBNC_SHORT_US * (`PGS_CLK_HZ / 1000000))
`define PGS_DBNC_LONG_CYC (`PGS_DBNC_LONG_MS * (`PGS_CLK_HZ / 1000))
`define PGS_CHG_DBNC_CYC (`PGS_CHG_DBNC_MS * (`PGS_CLK_HZ / 1000))
`define PGS_MRST_SHORT_CYC (`PGS_MRST_SHORT_MS * (`PGS_CLK_HZ / 1000))
`define PGS_MRST_LONG_CYC (`PGS_MRST_LONG_MS * (`PGS_CLK_HZ / 1000))
`endif

// ==== shared/pgs_pkg.sv ====
// types of the global supervisor
package pgs_pkg;
  typedef enum logic [1:0] {
    PGS_STANDBY,
    PGS_UV_CHECK,
    PGS_RESOURCE_ON
  } pgs_state_t;
endpackage

// ==== verification/pgs_key_model.sv ====
// on-key switch and host interrupt line model
`timescale 1ns/1ps
`default_nettype none
module pgs_key_model (
  input wire logic clk_i,
  input wire logic press_i,
  input wire logic bounce_i,
  input wire logic irq_oe_i,
  input wire logic irq_dat_i,
  output logic on_key_input_n_o,
  output logic irq_line_o
);
  logic chatter_reg = 1'b0;
  always @(posedge clk_i) begin
    chatter_reg <= ~chatter_reg;
  end
  // contacts chatter every cycle while bouncing, never a clean level
  assign on_key_input_n_o = bounce_i ? chatter_reg : ~press_i;
  // host side pull-up: a released pin reads high
  assign irq_line_o = irq_oe_i ? irq_dat_i : 1'b1;
endmodule
`default_nettype wire

// ==== verification/pgs_supervisor_bench.sv ====
// self-checking bench of the global supervisor
`timescale 1ns/1ps
`default_nettype none
module pgs_supervisor_bench;
  logic clk = 1'b0, rst = 1'b1, por = 1'b0, uv = 1'b0, ov = 1'b0, th = 1'b0, chg = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sel = 1'b0, press = 1'b0, bounce = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [7:0] dat = 8'h00, q;
  wire logic [7:0] rd;
  wire logic ack, uve, ove, ron, pup, pdn, irq_d, irq_oe, key_n, irq;
  int err_total = 0, checks_done = 0;
  always #5 clk = ~clk;
  pgs_supervisor #(.DBNC_SHORT_CYC(5), .DBNC_LONG_CYC(20), .CHG_DBNC_CYC(10), .MRST_SHORT_CYC(30),
    .MRST_LONG_CYC(60)) i_dut (.clk_i(clk), .rst_i(rst), .supply_por_reset_flag_i(por),
    .supply_undervoltage_flag_i(uv), .sys_overvoltage_flag_i(ov), .thermal_shutdown_flag_i(th),
    .on_key_input_n_i(key_n), .charger_input_supply_i(chg), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rd), .wb_ack_o(ack),
    .uvlo_enable_o(uve), .ovlo_enable_o(ove), .resource_on_o(ron), .power_up_start_o(pup),
    .power_down_start_o(pdn), .interrupt_out_n_o(irq_d), .interrupt_out_n_oe_o(irq_oe));
  pgs_key_model i_key (.clk_i(clk), .press_i(press), .bounce_i(bounce), .irq_oe_i(irq_oe),
    .irq_dat_i(irq_d), .on_key_input_n_o(key_n), .irq_line_o(irq));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  // ack is looked at mid-cycle, so it is the value the next rising edge samples
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 1'b1};
    do begin
      @(negedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    @(posedge clk);
    q = rd;
    {cyc, stb} <= 2'b00;
    if (n >= 20) begin
      chk("bus ack", 8'h01, 8'h00);
      finish_test();
    end
  endtask
  task automatic wt(input logic dn, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((dn ? pdn : pup) !== 1'b1 && n < lim);
    if (n >= lim) begin
      chk("sequencer pulse", 8'h01, 8'h00);
      finish_test();
    end
  endtask
  task automatic t_reset();
    bus(0, 4'h2, 0); chk("mask", 8'h0F, q);
    bus(0, 4'h0, 0); chk("config", 8'h00, q);
    bus(1, 4'h4, 8'hFF); bus(0, 4'h4, 0); chk("chip id", 8'h0A, q);
    bus(0, 4'h7, 0); chk("unmapped", 8'h00, q);
    chk("irq idle", 8'h01, irq);
    chk("uv ov off", 8'h00, {uve, ove});
    $display("reset test done");
  endtask
  task automatic t_powerup();
    bus(1, 4'h2, 8'h0E);
    @(posedge clk) bounce <= 1'b1;
    repeat (4) @(posedge clk);
    {bounce, press} <= 2'b01;
    wt(0, 30); chk("on", 8'h01, ron);
    chk("uv ov on", 8'h03, {uve, ove});
    repeat (2) @(negedge clk); chk("irq low", 8'h00, irq);
    bus(0, 4'h1, 0); chk("fall flag", 8'h01, q);
    chk("irq cleared", 8'h01, irq);
    wt(1, 50); chk("mrst off", 8'h00, ron);
    @(posedge clk) press <= 1'b0;
    repeat (12) @(posedge clk);
    chk("irq masked", 8'h01, irq);
    bus(0, 4'h1, 0); chk("masked rise flag", 8'h02, q);
    $display("power-up test done");
  endtask
  task automatic t_lockout();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) {uv, ov, press} <= {i[0], ~i[0], 1'b1};
      repeat (20) @(negedge clk); chk("locked out", 8'h00, ron);
      @(posedge clk) {uv, ov, press} <= 3'b000;
      repeat (12) @(posedge clk);
    end
    $display("lockout test done");
  endtask
  task automatic t_slide();
    bus(1, 4'h0, 8'h07);
    @(posedge clk) press <= 1'b1;
    repeat (15) @(negedge clk); chk("long debounce", 8'h00, ron);
    wt(0, 20); chk("slide on", 8'h01, ron);
    @(posedge clk) press <= 1'b0;
    // the short manual-reset time would already have fired here
    repeat (60) @(negedge clk); chk("long mrst", 8'h01, ron);
    wt(1, 40); chk("slide mrst", 8'h00, ron);
    bus(1, 4'h0, 8'h00);
    $display("slide test done");
  endtask
  task automatic t_charger();
    @(posedge clk) chg <= 1'b1;
    repeat (6) @(posedge clk);
    chg <= 1'b0;
    repeat (4) @(negedge clk); chk("short chg", 8'h00, ron);
    @(posedge clk) chg <= 1'b1;
    wt(0, 30); chk("chg wake", 8'h01, ron);
    bus(0, 4'h1, 0); chk("chg flag", 8'h04, q & 8'h04);
    bus(1, 4'h2, 8'h07);
    @(posedge clk) th <= 1'b1;
    wt(1, 20); chk("thermal off", 8'h00, ron);
    repeat (2) @(negedge clk); chk("thermal irq", 8'h00, irq);
    @(posedge clk) {th, chg} <= 2'b00;
    $display("charger thermal test done");
  endtask
  task automatic t_por();
    @(posedge clk) por <= 1'b1;
    repeat (6) @(posedge clk);
    por <= 1'b0;
    repeat (4) @(posedge clk);
    bus(0, 4'h2, 0); chk("por mask", 8'h0F, q);
    chk("por irq", 8'h01, irq);
    $display("por test done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_powerup();
    t_lockout();
    t_slide();
    t_charger();
    t_por();
    finish_test();
  end
endmodule
`default_nettype wire
